/* File: common/aicr_pkg.sv */
// Package for the converter configuration register slice
package aicr_pkg;

  localparam int unsigned AICR_AW = 8;
  localparam int unsigned AICR_DW = 8;

  // Register offsets
  localparam logic [7:0] AICR_OFS_AC_HYST = 8'h55;
  localparam logic [7:0] AICR_OFS_COARSE_OFS = 8'h60;
  localparam logic [7:0] AICR_OFS_FINE_OFS = 8'h61;
  localparam logic [7:0] AICR_OFS_MED_GAIN = 8'h62;
  localparam logic [7:0] AICR_OFS_FINE_GAIN = 8'h63;
  localparam logic [7:0] AICR_OFS_SAMPLE_SKEW = 8'h64;
  localparam logic [7:0] AICR_OFS_DIFF_TIMING = 8'h70;
  localparam logic [7:0] AICR_OFS_PHASE_STEP = 8'h71;
  localparam logic [7:0] AICR_OFS_RSVD_ZERO = 8'h72;
  localparam logic [7:0] AICR_OFS_DRIVE_FMT = 8'h73;
  localparam logic [7:0] AICR_OFS_TIMING_OPT = 8'h74;
  localparam logic [7:0] AICR_OFS_CFG_CHECK = 8'h75;

  // Values after reset
  localparam logic [7:0] AICR_RST_AC_HYST = 8'h00;
  localparam logic [7:0] AICR_RST_SEED = 8'h00;
  localparam logic [7:0] AICR_RST_FINE_GAIN = 8'h80;
  localparam logic [7:0] AICR_RST_SAMPLE_SKEW = 8'h80;
  localparam logic [7:0] AICR_RST_DIFF_TIMING = 8'h80;
  localparam logic [7:0] AICR_RST_PHASE_STEP = 8'h00;
  localparam logic [7:0] AICR_RST_RSVD_ZERO = 8'h00;
  localparam logic [7:0] AICR_RST_DRIVE_FMT = 8'h00;
  localparam logic [7:0] AICR_RST_TIMING_OPT = 8'h00;

  // Field positions
  localparam int unsigned AICR_FMT_LSB = 0;
  localparam int unsigned AICR_DRV_LSB = 5;
  localparam int unsigned AICR_DLL_BIT = 6;
  localparam int unsigned AICR_PHASE_BIT = 0;

  typedef enum logic [2:0] {
    AICR_DRV_PIN = 3'h0,
    AICR_DRV_LVDS_2MA = 3'h1,
    AICR_DRV_LVDS_3MA = 3'h2,
    AICR_DRV_LVCMOS = 3'h4
  } aicr_drive_t;

  typedef enum logic [2:0] {
    AICR_FMT_PIN = 3'h0,
    AICR_FMT_TWOS = 3'h1,
    AICR_FMT_GRAY = 3'h2,
    AICR_FMT_OFFSET_BIN = 3'h4
  } aicr_format_t;

  // Register access request from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aicr_req_t;

  // Seeds handed to the interleave correction engine
  typedef struct packed {
    logic [7:0] ac_hyst;
    logic [7:0] coarse_ofs;
    logic [7:0] fine_ofs;
    logic [7:0] med_gain;
    logic [7:0] fine_gain;
    logic [7:0] sample_skew;
  } aicr_seed_t;

  // Decoded output configuration
  typedef struct packed {
    logic drive_valid;
    logic [2:0] drive;
    logic format_valid;
    logic [2:0] format;
    logic dll_slow;
    logic [7:0] diff_timing;
    logic phase_step;
  } aicr_outcfg_t;

endpackage

/* File: hdl/aicr_decode.sv */
// Decoder of the output drive and format fields
`timescale 1ns/1ps
module aicr_decode
  import aicr_pkg::*;
(
  input wire logic [7:0] drive_fmt,
  input wire logic [7:0] timing_opt,
  output logic drive_valid,
  output logic [2:0] drive,
  output logic format_valid,
  output logic [2:0] format,
  output logic dll_slow
);

  always_comb
  begin
    drive = drive_fmt[AICR_DRV_LSB +: 3];
    format = drive_fmt[AICR_FMT_LSB +: 3];
    dll_slow = timing_opt[AICR_DLL_BIT];
    // Reserved codes flagged invalid
    case (drive)
      AICR_DRV_PIN, AICR_DRV_LVDS_2MA, AICR_DRV_LVDS_3MA, AICR_DRV_LVCMOS: drive_valid = 1'b1;
      default: drive_valid = 1'b0;
    endcase
    case (format)
      AICR_FMT_PIN, AICR_FMT_TWOS, AICR_FMT_GRAY, AICR_FMT_OFFSET_BIN: format_valid = 1'b1;
      default: format_valid = 1'b0;
    endcase
  end

endmodule // aicr_decode

/* File: hdl/aicr_regs.sv */
// Interleave seed and output configuration register bank
//
// How it works
// - Offset 0x55 holds an 8-bit hysteresis for the engine's AC power detector.
// - Offset 0x60 holds the coarse offset value loaded when the correction loop starts.
// - Offset 0x61 holds the fine offset value loaded when the correction loop starts.
// - Offset 0x62 holds the medium gain value loaded when the correction loop starts.
// - Offset 0x63 holds the fine gain start value and resets to 0x80.
// - Offset 0x64 holds the sample-time skew start value and resets to 0x80.
// - Offset 0x73 selects output driver and data format with 3-bit codes, others reserved.
`timescale 1ns/1ps
module aicr_regs
  import aicr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire aicr_req_t req,
  input wire logic [7:0] cfg_check,
  output logic [7:0] rdata,
  output logic rvalid,
  output aicr_seed_t seed,
  output aicr_outcfg_t outcfg
);

  ////////////////////////////////////////////////////////////////////////////
  // Soft-reset domain: seeds and global timing
  logic [7:0] ac_hyst_r, ac_hyst_nxt;
  logic [7:0] coarse_ofs_r, coarse_ofs_nxt;
  logic [7:0] fine_ofs_r, fine_ofs_nxt;
  logic [7:0] med_gain_r, med_gain_nxt;
  logic [7:0] fine_gain_r, fine_gain_nxt;
  logic [7:0] sample_skew_r, sample_skew_nxt;
  logic [7:0] diff_timing_r, diff_timing_nxt;
  logic [7:0] phase_step_r, phase_step_nxt;

  always_comb
  begin
    ac_hyst_nxt = ac_hyst_r;
    coarse_ofs_nxt = coarse_ofs_r;
    fine_ofs_nxt = fine_ofs_r;
    med_gain_nxt = med_gain_r;
    fine_gain_nxt = fine_gain_r;
    sample_skew_nxt = sample_skew_r;
    diff_timing_nxt = diff_timing_r;
    phase_step_nxt = phase_step_r;
    if (soft_rst)
    begin
      ac_hyst_nxt = AICR_RST_AC_HYST;
      coarse_ofs_nxt = AICR_RST_SEED;
      fine_ofs_nxt = AICR_RST_SEED;
      med_gain_nxt = AICR_RST_SEED;
      fine_gain_nxt = AICR_RST_FINE_GAIN;
      sample_skew_nxt = AICR_RST_SAMPLE_SKEW;
      diff_timing_nxt = AICR_RST_DIFF_TIMING;
      phase_step_nxt = AICR_RST_PHASE_STEP;
    end
    else if (req.wr)
    begin
      case (req.addr)
        AICR_OFS_AC_HYST: ac_hyst_nxt = req.wdata;
        AICR_OFS_COARSE_OFS: coarse_ofs_nxt = req.wdata;
        AICR_OFS_FINE_OFS: fine_ofs_nxt = req.wdata;
        AICR_OFS_MED_GAIN: med_gain_nxt = req.wdata;
        AICR_OFS_FINE_GAIN: fine_gain_nxt = req.wdata;
        AICR_OFS_SAMPLE_SKEW: sample_skew_nxt = req.wdata;
        AICR_OFS_DIFF_TIMING: diff_timing_nxt = req.wdata;
        AICR_OFS_PHASE_STEP: phase_step_nxt = {7'h00, req.wdata[AICR_PHASE_BIT]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ac_hyst_r <= AICR_RST_AC_HYST;
      coarse_ofs_r <= AICR_RST_SEED;
      fine_ofs_r <= AICR_RST_SEED;
      med_gain_r <= AICR_RST_SEED;
      fine_gain_r <= AICR_RST_FINE_GAIN;
      sample_skew_r <= AICR_RST_SAMPLE_SKEW;
      diff_timing_r <= AICR_RST_DIFF_TIMING;
      phase_step_r <= AICR_RST_PHASE_STEP;
    end
    else
    begin
      ac_hyst_r <= ac_hyst_nxt;
      coarse_ofs_r <= coarse_ofs_nxt;
      fine_ofs_r <= fine_ofs_nxt;
      med_gain_r <= med_gain_nxt;
      fine_gain_r <= fine_gain_nxt;
      sample_skew_r <= sample_skew_nxt;
      diff_timing_r <= diff_timing_nxt;
      phase_step_r <= phase_step_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Full-reset domain: output configuration, soft reset ignored
  logic [7:0] rsvd_zero_r, rsvd_zero_nxt;
  logic [7:0] drive_fmt_r, drive_fmt_nxt;
  logic [7:0] timing_opt_r, timing_opt_nxt;

  always_comb
  begin
    rsvd_zero_nxt = rsvd_zero_r;
    drive_fmt_nxt = drive_fmt_r;
    timing_opt_nxt = timing_opt_r;
    if (req.wr)
    begin
      case (req.addr)
        AICR_OFS_RSVD_ZERO: rsvd_zero_nxt = req.wdata;
        AICR_OFS_DRIVE_FMT: drive_fmt_nxt = req.wdata;
        AICR_OFS_TIMING_OPT: timing_opt_nxt = req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rsvd_zero_r <= AICR_RST_RSVD_ZERO;
      drive_fmt_r <= AICR_RST_DRIVE_FMT;
      timing_opt_r <= AICR_RST_TIMING_OPT;
    end
    else
    begin
      rsvd_zero_r <= rsvd_zero_nxt;
      drive_fmt_r <= drive_fmt_nxt;
      timing_opt_r <= timing_opt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, registered
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  always_comb
  begin
    rvalid_nxt = req.rd;
    rdata_nxt = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        AICR_OFS_AC_HYST: rdata_nxt = ac_hyst_r;
        AICR_OFS_COARSE_OFS: rdata_nxt = coarse_ofs_r;
        AICR_OFS_FINE_OFS: rdata_nxt = fine_ofs_r;
        AICR_OFS_MED_GAIN: rdata_nxt = med_gain_r;
        AICR_OFS_FINE_GAIN: rdata_nxt = fine_gain_r;
        AICR_OFS_SAMPLE_SKEW: rdata_nxt = sample_skew_r;
        AICR_OFS_DIFF_TIMING: rdata_nxt = diff_timing_r;
        AICR_OFS_PHASE_STEP: rdata_nxt = phase_step_r;
        AICR_OFS_RSVD_ZERO: rdata_nxt = rsvd_zero_r;
        AICR_OFS_DRIVE_FMT: rdata_nxt = drive_fmt_r;
        AICR_OFS_TIMING_OPT: rdata_nxt = timing_opt_r;
        AICR_OFS_CFG_CHECK: rdata_nxt = cfg_check;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the correction engine and output stage
  logic dec_drive_valid, dec_format_valid, dec_dll_slow;
  logic [2:0] dec_drive, dec_format;

  always_comb
  begin
    seed.ac_hyst = ac_hyst_r;
    seed.coarse_ofs = coarse_ofs_r;
    seed.fine_ofs = fine_ofs_r;
    seed.med_gain = med_gain_r;
    seed.fine_gain = fine_gain_r;
    seed.sample_skew = sample_skew_r;
    outcfg.diff_timing = diff_timing_r;
    outcfg.phase_step = phase_step_r[AICR_PHASE_BIT];
    outcfg.drive_valid = dec_drive_valid;
    outcfg.drive = dec_drive;
    outcfg.format_valid = dec_format_valid;
    outcfg.format = dec_format;
    outcfg.dll_slow = dec_dll_slow;
  end

  aicr_decode u_decode (
    .drive_fmt(drive_fmt_r),
    .timing_opt(timing_opt_r),
    .drive_valid(dec_drive_valid),
    .drive(dec_drive),
    .format_valid(dec_format_valid),
    .format(dec_format),
    .dll_slow(dec_dll_slow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_fine_gain_reset: assert property (@(posedge sys_clk)
    !rst_n |=> fine_gain_r == AICR_RST_FINE_GAIN)
    else $error("fine gain seed not 0x80 after reset");

  a_skew_reset: assert property (@(posedge sys_clk)
    !rst_n |=> sample_skew_r == AICR_RST_SAMPLE_SKEW)
    else $error("sample skew seed not 0x80 after reset");

  a_hyst_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.wr && !soft_rst && req.addr == AICR_OFS_AC_HYST |=> seed.ac_hyst == $past(req.wdata))
    else $error("hysteresis write not stored");

  a_coarse_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.wr && !soft_rst && req.addr == AICR_OFS_COARSE_OFS |=> seed.coarse_ofs == $past(req.wdata))
    else $error("coarse offset write not stored");

  a_fine_ofs_rd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.rd && req.addr == AICR_OFS_FINE_OFS |=> rvalid && rdata == $past(fine_ofs_r))
    else $error("fine offset readback wrong");

  a_med_gain_rd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.wr && !soft_rst && req.addr == AICR_OFS_MED_GAIN ##1 req.rd && req.addr == AICR_OFS_MED_GAIN
    |=> rdata == $past(req.wdata, 2))
    else $error("medium gain write then read mismatch");

  a_rsvd_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.wr && req.addr == AICR_OFS_RSVD_ZERO |=> rsvd_zero_r == $past(req.wdata))
    else $error("reserved register not stored");

  a_drive_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    outcfg.drive_valid == (outcfg.drive inside {3'h0, 3'h1, 3'h2, 3'h4}) &&
    outcfg.format_valid == (outcfg.format inside {3'h0, 3'h1, 3'h2, 3'h4}))
    else $error("drive or format decode wrong");

  a_soft_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    soft_rst && !req.wr |=> $stable(drive_fmt_r) && $stable(timing_opt_r) && $stable(rsvd_zero_r))
    else $error("output config changed on soft reset");

  a_dll_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req.wr && req.addr == AICR_OFS_TIMING_OPT |=> outcfg.dll_slow == $past(req.wdata[6]))
    else $error("dll range not taken from bit 6");

endmodule // aicr_regs

/* File: verif/aicr_host_model.sv */
// Serial host model issuing single register requests
`timescale 1ns/1ps
module aicr_host_model
  import aicr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output aicr_req_t req
);
  initial req = '0;

  // Request held for one taken edge, answer sampled after it lands
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic v);
    @(posedge sys_clk);
    req <= '{wr: wr, rd: !wr, addr: a, wdata: (a == AICR_OFS_RSVD_ZERO) ? 8'h00 : d};
    @(posedge sys_clk);
    req <= '0;
    #1;
    q = rdata;
    v = rvalid;
  endtask

  // Write then read of one offset on consecutive edges
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic v);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: (a == AICR_OFS_RSVD_ZERO) ? 8'h00 : d};
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    req <= '0;
    #1;
    q = rdata;
    v = rvalid;
  endtask
endmodule // aicr_host_model

/* File: verif/test_aicr_regs.sv */
// Self-checking bench for the configuration register slice
`timescale 1ns/1ps
module test_aicr_regs
  import aicr_pkg::*;
;
  logic sys_clk, rst_n, soft_rst, rvalid, v, ok_code;
  logic [7:0] cfg_check, rdata, q, a;
  logic [7:0] mem [256];
  aicr_req_t req;
  aicr_seed_t seed;
  aicr_outcfg_t outcfg;
  int num_errors = 0;
  int check_count = 0;

  aicr_regs dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .soft_rst(soft_rst), .req(req),
    .cfg_check(cfg_check), .rdata(rdata), .rvalid(rvalid), .seed(seed), .outcfg(outcfg));
  aicr_host_model host_u (.sys_clk(sys_clk), .rdata(rdata), .rvalid(rvalid), .req(req));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic mapped(input logic [7:0] x);
    return x inside {8'h55, [8'h60:8'h64], [8'h70:8'h75]};
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] x);
    return mapped(x) ? ((x == 8'h75) ? cfg_check : mem[x]) : 8'h00;
  endfunction

  // Soft reset spares the output mode group
  task automatic reset_model(input logic full);
    for (int i = 0; i < 256; i++)
      if (mapped(8'(i)) && (full || !(i inside {[8'h72:8'h74]})))
        mem[i] = (i inside {8'h63, 8'h64, 8'h70}) ? 8'h80 : 8'h00;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    host_u.xfer(1'b1, x, d, q, v);
    chk({7'h0, v}, 8'h00, "rvalid on write");
    if (mapped(x) && x != 8'h75)
      mem[x] = (x == 8'h71) ? (d & 8'h01) : ((x == 8'h72) ? 8'h00 : d);
  endtask

  task automatic rd(input logic [7:0] x);
    host_u.xfer(1'b0, x, 8'h00, q, v);
    chk({7'h0, v}, 8'h01, "rvalid on read");
    chk(q, exp_rd(x), "read data");
  endtask

  task automatic rd_all;
    for (int i = 0; i < 256; i++)
      if (mapped(8'(i)))
        rd(8'(i));
    rd(8'h56);
  endtask

  task automatic chk_seed;
    chk(seed.ac_hyst, mem[8'h55], "hysteresis");
    chk(seed.coarse_ofs, mem[8'h60], "coarse offset");
    chk(seed.fine_ofs, mem[8'h61], "fine offset");
    chk(seed.med_gain, mem[8'h62], "medium gain");
    chk(seed.fine_gain, mem[8'h63], "fine gain");
    chk(seed.sample_skew, mem[8'h64], "sample skew");
  endtask

  task automatic chk_outcfg;
    chk({5'h0, outcfg.drive}, {5'h0, mem[8'h73][7:5]}, "drive field");
    chk({5'h0, outcfg.format}, {5'h0, mem[8'h73][2:0]}, "format field");
    chk({7'h0, outcfg.dll_slow}, {7'h0, mem[8'h74][6]}, "dll range");
    chk(outcfg.diff_timing, mem[8'h70], "differential timing");
    chk({7'h0, outcfg.phase_step}, mem[8'h71], "phase step");
  endtask

  // Write and read back on consecutive edges
  task automatic wr_then_rd(input logic [7:0] x, input logic [7:0] d);
    host_u.wr_rd(x, d, q, v);
    mem[x] = d;
    chk({7'h0, v}, 8'h01, "rvalid back to back");
    chk(q, exp_rd(x), "back to back read");
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #50us;
    num_errors++;
    conclude();
  end

  initial
  begin
    rst_n = 1'b0;
    soft_rst = 1'b0;
    cfg_check = 8'h00;
    void'($urandom(32'hbf00));
    reset_model(1'b1);
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    cfg_check <= 8'($urandom);
    rd_all();
    chk_seed();
    // Random traffic over the mapped span and its holes
    repeat (60)
    begin
      a = 8'h50 + 8'($urandom_range(0, 37));
      wr(a, 8'($urandom));
      rd(a);
    end
    wr_then_rd(8'h62, 8'($urandom));
    chk_seed();
    chk_outcfg();
    for (int c = 0; c < 8; c++)
    begin
      ok_code = c inside {0, 1, 2, 4};
      wr(8'h73, {c[2:0], 2'b00, c[2:0]});
      chk({7'h0, outcfg.drive_valid}, {7'h0, ok_code}, "drive valid");
      chk({5'h0, outcfg.drive}, {5'h0, c[2:0]}, "drive code");
      chk({7'h0, outcfg.format_valid}, {7'h0, ok_code}, "format valid");
      chk({5'h0, outcfg.format}, {5'h0, c[2:0]}, "format code");
    end
    wr(8'h74, 8'h40);
    chk({7'h0, outcfg.dll_slow}, 8'h01, "slow range");
    wr(8'h74, 8'hbf);
    chk({7'h0, outcfg.dll_slow}, 8'h00, "fast range");
    wr(8'h73, 8'h24);
    wr(8'h74, 8'h40);
    wr(8'h63, 8'h11);
    @(posedge sys_clk) soft_rst <= 1'b1;
    wr(8'h60, 8'h5a);
    @(posedge sys_clk) soft_rst <= 1'b0;
    reset_model(1'b0);
    rd_all();
    chk_seed();
    chk_outcfg();
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    reset_model(1'b1);
    rd_all();
    chk_seed();
    chk_outcfg();
    conclude();
  end
endmodule // test_aicr_regs
